// *** hdl/svc_pkg.sv ***
package svc_pkg;

	// Clock
	localparam int unsigned CLK_FREQ_MHZ  = 100;
	localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
	localparam logic [31:0] CLK_STEP_NS   = CLK_PERIOD_NS[31:0];

	// Object indices
	localparam logic [15:0] IDX_CTRL     = 16'h6040;
	localparam logic [15:0] IDX_STAT     = 16'h6041;
	localparam logic [15:0] IDX_MODE     = 16'h6060;
	localparam logic [15:0] IDX_MAX_TRQ  = 16'h6072;
	localparam logic [15:0] IDX_TGT_POS  = 16'h607A;
	localparam logic [15:0] IDX_SW_LIM   = 16'h607D;
	localparam logic [15:0] IDX_MAX_PVEL = 16'h607F;
	localparam logic [15:0] IDX_MAX_MSPD = 16'h6080;
	localparam logic [15:0] IDX_PVEL     = 16'h6081;
	localparam logic [15:0] IDX_PACC     = 16'h6083;
	localparam logic [15:0] IDX_PDEC     = 16'h6084;
	localparam logic [15:0] IDX_MAX_ACC  = 16'h60C5;
	localparam logic [15:0] IDX_MAX_DEC  = 16'h60C6;
	localparam logic [15:0] IDX_EXT6     = 16'h3799;
	localparam logic [15:0] IDX_SM_OUT   = 16'h1C32;
	localparam logic [15:0] IDX_SM_IN    = 16'h1C33;

	localparam logic [7:0] SUB0 = 8'h00;
	localparam logic [7:0] SUB1 = 8'h01;
	localparam logic [7:0] SUB2 = 8'h02;
	localparam logic [7:0] SUB3 = 8'h03;

	// Index and subindex joined into one lookup key
	localparam logic [23:0] K_CTRL     = {IDX_CTRL, SUB0};
	localparam logic [23:0] K_STAT     = {IDX_STAT, SUB0};
	localparam logic [23:0] K_MODE     = {IDX_MODE, SUB0};
	localparam logic [23:0] K_MAX_TRQ  = {IDX_MAX_TRQ, SUB0};
	localparam logic [23:0] K_TGT_POS  = {IDX_TGT_POS, SUB0};
	localparam logic [23:0] K_LIM_MIN  = {IDX_SW_LIM, SUB1};
	localparam logic [23:0] K_LIM_MAX  = {IDX_SW_LIM, SUB2};
	localparam logic [23:0] K_MAX_PVEL = {IDX_MAX_PVEL, SUB0};
	localparam logic [23:0] K_MAX_MSPD = {IDX_MAX_MSPD, SUB0};
	localparam logic [23:0] K_PVEL     = {IDX_PVEL, SUB0};
	localparam logic [23:0] K_PACC     = {IDX_PACC, SUB0};
	localparam logic [23:0] K_PDEC     = {IDX_PDEC, SUB0};
	localparam logic [23:0] K_MAX_ACC  = {IDX_MAX_ACC, SUB0};
	localparam logic [23:0] K_MAX_DEC  = {IDX_MAX_DEC, SUB0};
	localparam logic [23:0] K_EXT6     = {IDX_EXT6, SUB0};
	localparam logic [23:0] K_OUT_TYPE = {IDX_SM_OUT, SUB1};
	localparam logic [23:0] K_OUT_CYC  = {IDX_SM_OUT, SUB2};
	localparam logic [23:0] K_IN_TYPE  = {IDX_SM_IN, SUB1};
	localparam logic [23:0] K_IN_SHIFT = {IDX_SM_IN, SUB3};

	// Values
	localparam logic [7:0]  MODE_PP       = 8'h01;
	localparam logic [7:0]  MODE_HM       = 8'h06;
	localparam logic [15:0] SYNC_DC       = 16'h0002;
	localparam logic [15:0] CW_CMD_MASK   = 16'h008F;
	localparam logic [15:0] CW_DISABLE_V  = 16'h0000;
	localparam logic [15:0] CW_QUICK_STOP = 16'h0002;
	localparam logic [15:0] CW_SHUTDOWN   = 16'h0006;
	localparam logic [15:0] CW_SWITCH_ON  = 16'h0007;
	localparam logic [15:0] CW_ENABLE_OP  = 16'h000F;
	localparam int unsigned CW_NEW_SP_BIT = 4;
	localparam int unsigned EXT6_TOOL_BIT = 0;
	localparam int unsigned SW_LIMIT_BIT  = 11;
	localparam int unsigned SW_MODE_BIT   = 12;
	localparam logic [7:0]  SW_SOD        = 8'h40;
	localparam logic [7:0]  SW_RTSO       = 8'h21;
	localparam logic [7:0]  SW_SO         = 8'h23;
	localparam logic [7:0]  SW_OE         = 8'h27;

	// Reset values
	localparam logic [31:0] DEF_MAX       = 32'hFFFF_FFFF;
	localparam logic [31:0] DEF_ZERO      = 32'h0000_0000;
	localparam logic [15:0] DEF_MAX_TRQ   = 16'hFFFF;
	localparam logic [15:0] TORQUE_FULL   = 16'hFFFF;
	localparam logic [15:0] DEF_SYNC_TYPE = 16'h0000;
	localparam logic [31:0] DEF_CYCLE_NS  = 32'h001E_8480;
	localparam logic [31:0] DEF_SHIFT_NS  = 32'h0000_0000;
	localparam logic [15:0] DEF_EXT6      = 16'h0000;

	typedef enum logic [3:0] {
		CS_INIT   = 4'b0001,
		CS_PREOP  = 4'b0010,
		CS_SAFEOP = 4'b0100,
		CS_OP     = 4'b1000
	} svc_comm_t;

	typedef enum logic [1:0] {
		PS_SOD  = 2'b00,
		PS_RTSO = 2'b01,
		PS_SO   = 2'b10,
		PS_OE   = 2'b11
	} svc_pwr_t;

endpackage

// *** hdl/svc_limit_clamp.sv ***
`timescale 1ns/1ps
module svc_limit_clamp (
	input  wire logic [31:0] tgt_pos,
	input  wire logic [31:0] lim_min,
	input  wire logic [31:0] lim_max,
	input  wire logic [31:0] pvel,
	input  wire logic [31:0] max_pvel,
	input  wire logic [31:0] max_mspd,
	input  wire logic [31:0] pacc,
	input  wire logic [31:0] max_acc,
	input  wire logic [31:0] pdec,
	input  wire logic [31:0] max_dec,
	output logic      [31:0] pos_out,
	output logic      [31:0] vel_out,
	output logic      [31:0] acc_out,
	output logic      [31:0] dec_out,
	output logic             limited
);
	logic        lim_en;
	logic        pos_lo;
	logic        pos_hi;
	logic [31:0] vel_cap;

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		umin = (a < b) ? a : b;
	endfunction

	// Range counts as enabled only when it is a real interval
	assign lim_en  = $signed(lim_min) < $signed(lim_max);
	assign pos_lo  = lim_en && ($signed(tgt_pos) < $signed(lim_min));
	assign pos_hi  = lim_en && ($signed(tgt_pos) > $signed(lim_max));
	assign pos_out = pos_lo ? lim_min : (pos_hi ? lim_max : tgt_pos);
	assign vel_cap = umin(max_pvel, max_mspd);
	assign vel_out = umin(pvel, vel_cap);
	assign acc_out = umin(pacc, max_acc);
	assign dec_out = umin(pdec, max_dec);
	assign limited = pos_lo || pos_hi || (pvel > vel_cap) || (pacc > max_acc)
		|| (pdec > max_dec);
endmodule

// *** hdl/svc_drive_power_fsm.sv ***
`timescale 1ns/1ps
module svc_drive_power_fsm
	import svc_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          reset,
	input  wire logic          cw_wr,
	input  wire logic [15:0]   cw,
	input  wire logic          tool_srv,
	output svc_pkg::svc_pwr_t  state_r,
	output logic               setpoint_r,
	output logic               conflict_r
);
	svc_pwr_t    state_nxt;
	logic        sp_bit_r;
	logic        sp_bit_nxt;
	logic        setpoint_nxt;
	logic        conflict_nxt;
	logic [15:0] cmd;

	assign cmd = cw & CW_CMD_MASK;

	always_comb
	begin
		state_nxt    = state_r;
		sp_bit_nxt   = sp_bit_r;
		setpoint_nxt = 1'b0;
		conflict_nxt = 1'b0;
		if (cw_wr)
		begin
			sp_bit_nxt = cw[CW_NEW_SP_BIT];
			case (state_r)
				PS_SOD:
					if (cmd == CW_SHUTDOWN)
						state_nxt = PS_RTSO;
				PS_RTSO:
					if (cmd == CW_SWITCH_ON)
						state_nxt = PS_SO;
					else if (cmd == CW_DISABLE_V)
						state_nxt = PS_SOD;
				PS_SO:
					if (cmd == CW_ENABLE_OP)
					begin
						// Tool holds the servo: stay out of operation enabled
						if (tool_srv)
							conflict_nxt = 1'b1;
						else
							state_nxt = PS_OE;
					end
					else if (cmd == CW_SHUTDOWN)
						state_nxt = PS_RTSO;
					else if (cmd == CW_DISABLE_V)
						state_nxt = PS_SOD;
				PS_OE:
					if (cmd == CW_SWITCH_ON)
						state_nxt = PS_SO;
					else if (cmd == CW_SHUTDOWN)
						state_nxt = PS_RTSO;
					else if (cmd == CW_DISABLE_V)
						state_nxt = PS_SOD;
					else if (cmd == CW_QUICK_STOP && !tool_srv)
						state_nxt = PS_SOD;
					else if (cw[CW_NEW_SP_BIT] && !sp_bit_r)
						setpoint_nxt = 1'b1;
				default:
					state_nxt = PS_SOD;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_r    <= PS_SOD;
			sp_bit_r   <= 1'b0;
			setpoint_r <= 1'b0;
			conflict_r <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			sp_bit_r   <= sp_bit_nxt;
			setpoint_r <= setpoint_nxt;
			conflict_r <= conflict_nxt;
		end
	end
endmodule

// *** hdl/svc_drive_ctrl.sv ***
// Behaviour
// - DC mode example: 2 ms cycle, zero latch delay; both sync objects set DC.
// - Mode object value 1 selects profile position operation.
// - Enabled software position range restricts the commanded target position.
// - Profile velocity clamped to smaller of max profile velocity and motor speed.
// - Profile acceleration clamped to maximum acceleration.
// - Profile deceleration clamped to maximum deceleration.
// - Power state changes only by control word; status word shows it.
// - Shutdown 0006h in switch-on-disabled goes ready-to-switch-on, 40h to 21h.
// - Switch on 0007h in ready goes switched-on, 21h to 23h.
// - Enable 000Fh in switched-on enters operation enabled, servo on, 27h.
// - Rising bit 4 of control word starts a profile move.
// - Disable 0007h in operation enabled turns servo off, back to 23h.
// - Status bit 11 set while any internal limit restricts motion.
// - Tool commands during established link only when setup bit 0 is 1.
// - Tool object writes only in Init, taking effect at once.
// - Tool servo-on never enters operation enabled, quick stop inert, warning raised.
// - Host servo-on during tool run, or state change while running, raise errors.
// - Tool run in incremental mode leaves homing incomplete; bit 12 reads 0.
// - Maximum torque ignored in Init, applied from PreOP upward.
`timescale 1ns/1ps
module svc_drive_ctrl
	import svc_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            reset,
	input  wire logic            obj_wr,
	input  wire logic            obj_rd,
	input  wire logic [15:0]     obj_index,
	input  wire logic [7:0]      obj_sub,
	input  wire logic [31:0]     obj_wdata,
	output logic      [31:0]     obj_rdata,
	output logic                 obj_ack,
	output logic                 obj_abort,
	input  wire logic            comm_req,
	input  wire logic [3:0]      comm_req_state,
	output svc_pkg::svc_comm_t   comm_state,
	input  wire logic            tool_wr,
	input  wire logic [15:0]     tool_index,
	input  wire logic [7:0]      tool_sub,
	input  wire logic [31:0]     tool_wdata,
	output logic                 tool_ack,
	output logic                 tool_abort,
	input  wire logic            tool_servo_req,
	input  wire logic            tool_motor_run,
	input  wire logic            incremental_mode,
	input  wire logic            homing_done,
	input  wire logic            alarm_clear,
	output logic                 servo_on,
	output logic                 motion_start,
	output logic      [31:0]     target_pos_cmd,
	output logic      [31:0]     vel_cmd,
	output logic      [31:0]     acc_cmd,
	output logic      [31:0]     dec_cmd,
	output logic      [15:0]     torque_limit,
	output logic      [15:0]     status_word,
	output logic                 tool_command_warning,
	output logic                 command_conflict_error,
	output logic                 state_change_while_running_error,
	output logic                 sync_pulse,
	output logic                 latch_pulse
);
	function automatic logic [23:0] obj_key(input logic [15:0] idx, input logic [7:0] sub);
		obj_key = {idx, sub};
	endfunction

	// Object store
	logic [15:0] ctrl_r, ctrl_nxt, max_trq_r, max_trq_nxt, ext6_r, ext6_nxt;
	logic [15:0] out_type_r, out_type_nxt, in_type_r, in_type_nxt;
	logic [7:0]  mode_r, mode_nxt;
	logic [31:0] tgt_r, tgt_nxt, lmin_r, lmin_nxt, lmax_r, lmax_nxt;
	logic [31:0] mpvel_r, mpvel_nxt, mmspd_r, mmspd_nxt, pvel_r, pvel_nxt;
	logic [31:0] pacc_r, pacc_nxt, pdec_r, pdec_nxt, macc_r, macc_nxt;
	logic [31:0] mdec_r, mdec_nxt, cyc_r, cyc_nxt, shift_r, shift_nxt;
	// Link, tool and timing state
	svc_comm_t   comm_nxt;
	logic [31:0] phase_r, phase_nxt, rdata_nxt;
	logic        ack_nxt, abort_nxt, tack_nxt, tabort_nxt;
	logic        homed_r, homed_nxt, sp_ack_r, sp_ack_nxt;
	logic        warn_nxt, err_cf_nxt, err_sc_nxt, sync_nxt, latch_nxt;
	logic        servo_nxt, start_nxt;
	logic [15:0] status_nxt, torque_nxt;
	// Shared write path
	logic        tool_ok, tool_srv, tool_run, tool_wr_ok, wr_any, w_hit, cw_wr;
	logic [23:0] w_key;
	logic [31:0] w_data;
	logic        dc_active;
	// Submodule results
	svc_pwr_t    pwr_state;
	logic        fsm_setpoint, fsm_conflict, limited;
	logic [31:0] pos_c, vel_c, acc_c, dec_c;

	// Tool commands taken in Init, and out of Init only while setup bit 0 is 1
	assign tool_ok    = (comm_state == CS_INIT) || ext6_r[EXT6_TOOL_BIT];
	assign tool_srv   = tool_servo_req && tool_ok;
	assign tool_run   = tool_motor_run && tool_srv;
	// Master write wins a collision; the tool is refused that cycle
	assign tool_wr_ok = tool_wr && !obj_wr && (comm_state == CS_INIT);
	assign wr_any     = obj_wr || tool_wr_ok;
	assign w_key      = obj_wr ? obj_key(obj_index, obj_sub) : obj_key(tool_index, tool_sub);
	assign w_data     = obj_wr ? obj_wdata : tool_wdata;
	assign cw_wr      = wr_any && (w_key == K_CTRL);
	assign dc_active  = (out_type_r == SYNC_DC) && (in_type_r == SYNC_DC)
		&& (comm_state == CS_SAFEOP || comm_state == CS_OP);

	svc_drive_power_fsm u_pwr (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.cw_wr      (cw_wr),
		.cw         (w_data[15:0]),
		.tool_srv   (tool_srv),
		.state_r    (pwr_state),
		.setpoint_r (fsm_setpoint),
		.conflict_r (fsm_conflict)
	);

	svc_limit_clamp u_clamp (
		.tgt_pos  (tgt_r),
		.lim_min  (lmin_r),
		.lim_max  (lmax_r),
		.pvel     (pvel_r),
		.max_pvel (mpvel_r),
		.max_mspd (mmspd_r),
		.pacc     (pacc_r),
		.max_acc  (macc_r),
		.pdec     (pdec_r),
		.max_dec  (mdec_r),
		.pos_out  (pos_c),
		.vel_out  (vel_c),
		.acc_out  (acc_c),
		.dec_out  (dec_c),
		.limited  (limited)
	);

	always_comb
	begin
		ctrl_nxt = ctrl_r;    mode_nxt = mode_r;     max_trq_nxt = max_trq_r;
		tgt_nxt = tgt_r;      lmin_nxt = lmin_r;     lmax_nxt = lmax_r;
		mpvel_nxt = mpvel_r;  mmspd_nxt = mmspd_r;   pvel_nxt = pvel_r;
		pacc_nxt = pacc_r;    pdec_nxt = pdec_r;     macc_nxt = macc_r;
		mdec_nxt = mdec_r;    ext6_nxt = ext6_r;     out_type_nxt = out_type_r;
		cyc_nxt = cyc_r;      in_type_nxt = in_type_r; shift_nxt = shift_r;
		w_hit = 1'b1;
		if (wr_any)
		begin
			case (w_key)
				K_CTRL:     ctrl_nxt = w_data[15:0];
				K_MODE:     mode_nxt = w_data[7:0];
				K_MAX_TRQ:  max_trq_nxt = w_data[15:0];
				K_TGT_POS:  tgt_nxt = w_data;
				K_LIM_MIN:  lmin_nxt = w_data;
				K_LIM_MAX:  lmax_nxt = w_data;
				K_MAX_PVEL: mpvel_nxt = w_data;
				K_MAX_MSPD: mmspd_nxt = w_data;
				K_PVEL:     pvel_nxt = w_data;
				K_PACC:     pacc_nxt = w_data;
				K_PDEC:     pdec_nxt = w_data;
				K_MAX_ACC:  macc_nxt = w_data;
				K_MAX_DEC:  mdec_nxt = w_data;
				K_EXT6:     ext6_nxt = w_data[15:0];
				K_OUT_TYPE: out_type_nxt = w_data[15:0];
				K_OUT_CYC:  cyc_nxt = w_data;
				K_IN_TYPE:  in_type_nxt = w_data[15:0];
				K_IN_SHIFT: shift_nxt = w_data;
				default:    w_hit = 1'b0;
			endcase
		end
	end

	always_comb
	begin
		rdata_nxt  = obj_rdata;
		ack_nxt    = 1'b0;
		abort_nxt  = 1'b0;
		tack_nxt   = 1'b0;
		tabort_nxt = 1'b0;
		if (obj_wr)
		begin
			ack_nxt   = w_hit;
			abort_nxt = !w_hit;
		end
		else if (obj_rd)
		begin
			ack_nxt   = 1'b1;
			rdata_nxt = DEF_ZERO;
			case (obj_key(obj_index, obj_sub))
				K_CTRL:     rdata_nxt[15:0] = ctrl_r;
				K_STAT:     rdata_nxt[15:0] = status_word;
				K_MODE:     rdata_nxt[7:0] = mode_r;
				K_MAX_TRQ:  rdata_nxt[15:0] = max_trq_r;
				K_TGT_POS:  rdata_nxt = tgt_r;
				K_LIM_MIN:  rdata_nxt = lmin_r;
				K_LIM_MAX:  rdata_nxt = lmax_r;
				K_MAX_PVEL: rdata_nxt = mpvel_r;
				K_MAX_MSPD: rdata_nxt = mmspd_r;
				K_PVEL:     rdata_nxt = pvel_r;
				K_PACC:     rdata_nxt = pacc_r;
				K_PDEC:     rdata_nxt = pdec_r;
				K_MAX_ACC:  rdata_nxt = macc_r;
				K_MAX_DEC:  rdata_nxt = mdec_r;
				K_EXT6:     rdata_nxt[15:0] = ext6_r;
				K_OUT_TYPE: rdata_nxt[15:0] = out_type_r;
				K_OUT_CYC:  rdata_nxt = cyc_r;
				K_IN_TYPE:  rdata_nxt[15:0] = in_type_r;
				K_IN_SHIFT: rdata_nxt = shift_r;
				default:
				begin
					ack_nxt   = 1'b0;
					abort_nxt = 1'b1;
				end
			endcase
		end
		if (tool_wr)
		begin
			tack_nxt   = tool_wr_ok && w_hit;
			tabort_nxt = !(tool_wr_ok && w_hit);
		end
	end

	always_comb
	begin
		comm_nxt = comm_state;
		// One step up or any step down, and from OP a request of 0 is also taken; anything else is refused
		if (comm_req && (comm_req_state == {comm_state[2:0], 1'b0}
			|| (comm_req_state < comm_state && $onehot(comm_req_state))))
			comm_nxt = svc_comm_t'(comm_req_state);
		err_sc_nxt = (state_change_while_running_error && !alarm_clear)
			|| (tool_run && comm_nxt != comm_state);
		err_cf_nxt = (command_conflict_error && !alarm_clear)
			|| (fsm_conflict && tool_motor_run);
		warn_nxt   = tool_srv;
		homed_nxt  = homed_r || homing_done;
		// Tool motion in incremental mode wins over homing completion in the same cycle
		if (tool_run && incremental_mode)
			homed_nxt = 1'b0;
		sp_ack_nxt = (sp_ack_r || fsm_setpoint) && ctrl_r[CW_NEW_SP_BIT];
		start_nxt  = fsm_setpoint && (mode_r == MODE_PP);
		servo_nxt  = (pwr_state == PS_OE) || tool_srv;
		torque_nxt = (comm_state == CS_INIT) ? TORQUE_FULL : max_trq_r;
		status_nxt = 16'h0000;
		case (pwr_state)
			PS_SOD:  status_nxt[7:0] = SW_SOD;
			PS_RTSO: status_nxt[7:0] = SW_RTSO;
			PS_SO:   status_nxt[7:0] = SW_SO;
			PS_OE:   status_nxt[7:0] = SW_OE;
			default: status_nxt[7:0] = SW_SOD;
		endcase
		status_nxt[SW_LIMIT_BIT] = limited;
		status_nxt[SW_MODE_BIT]  = (mode_r == MODE_HM) ? homed_nxt : sp_ack_nxt;
		// Phase counted in ns without a divider; a cycle that is not a multiple of CLK_STEP_NS rounds up to the next step
		sync_nxt  = dc_active && (phase_r == DEF_ZERO);
		latch_nxt = dc_active && (phase_r <= shift_r) && (phase_r + CLK_STEP_NS > shift_r);
		if (!dc_active || phase_r + CLK_STEP_NS >= cyc_r)
			phase_nxt = DEF_ZERO;
		else
			phase_nxt = phase_r + CLK_STEP_NS;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl_r <= CW_DISABLE_V;  mode_r <= MODE_PP;  max_trq_r <= DEF_MAX_TRQ;
			tgt_r <= DEF_ZERO;       lmin_r <= DEF_ZERO; lmax_r <= DEF_ZERO;
			mpvel_r <= DEF_MAX;      mmspd_r <= DEF_MAX; pvel_r <= DEF_ZERO;
			pacc_r <= DEF_ZERO;      pdec_r <= DEF_ZERO; macc_r <= DEF_MAX;
			mdec_r <= DEF_MAX;       ext6_r <= DEF_EXT6; out_type_r <= DEF_SYNC_TYPE;
			cyc_r <= DEF_CYCLE_NS;   in_type_r <= DEF_SYNC_TYPE; shift_r <= DEF_SHIFT_NS;
			comm_state <= CS_INIT;   phase_r <= DEF_ZERO;
			obj_rdata <= DEF_ZERO;   obj_ack <= 1'b0;    obj_abort <= 1'b0;
			tool_ack <= 1'b0;        tool_abort <= 1'b0; homed_r <= 1'b0;
			sp_ack_r <= 1'b0;        servo_on <= 1'b0;   motion_start <= 1'b0;
			target_pos_cmd <= DEF_ZERO; vel_cmd <= DEF_ZERO;
			acc_cmd <= DEF_ZERO;     dec_cmd <= DEF_ZERO; torque_limit <= TORQUE_FULL;
			status_word <= {8'h00, SW_SOD};
			tool_command_warning <= 1'b0;
			command_conflict_error <= 1'b0;
			state_change_while_running_error <= 1'b0;
			sync_pulse <= 1'b0;      latch_pulse <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;      mode_r <= mode_nxt; max_trq_r <= max_trq_nxt;
			tgt_r <= tgt_nxt;        lmin_r <= lmin_nxt; lmax_r <= lmax_nxt;
			mpvel_r <= mpvel_nxt;    mmspd_r <= mmspd_nxt; pvel_r <= pvel_nxt;
			pacc_r <= pacc_nxt;      pdec_r <= pdec_nxt; macc_r <= macc_nxt;
			mdec_r <= mdec_nxt;      ext6_r <= ext6_nxt; out_type_r <= out_type_nxt;
			cyc_r <= cyc_nxt;        in_type_r <= in_type_nxt; shift_r <= shift_nxt;
			comm_state <= comm_nxt;  phase_r <= phase_nxt;
			obj_rdata <= rdata_nxt;  obj_ack <= ack_nxt; obj_abort <= abort_nxt;
			tool_ack <= tack_nxt;    tool_abort <= tabort_nxt; homed_r <= homed_nxt;
			sp_ack_r <= sp_ack_nxt;  servo_on <= servo_nxt; motion_start <= start_nxt;
			target_pos_cmd <= pos_c; vel_cmd <= vel_c;
			acc_cmd <= acc_c;        dec_cmd <= dec_c;   torque_limit <= torque_nxt;
			status_word <= status_nxt;
			tool_command_warning <= warn_nxt;
			command_conflict_error <= err_cf_nxt;
			state_change_while_running_error <= err_sc_nxt;
			sync_pulse <= sync_nxt;  latch_pulse <= latch_nxt;
		end
	end
endmodule

// *** testbench/svc_drive_ctrl_assertions.sv ***
`timescale 1ns/1ps
module svc_chk
	import svc_pkg::*;
(
	input wire logic               ref_clk,
	input wire logic               reset,
	input wire logic               obj_wr,
	input wire logic               obj_rd,
	input wire logic [15:0]        obj_index,
	input wire logic [7:0]         obj_sub,
	input wire logic [31:0]        obj_wdata,
	input wire logic               obj_ack,
	input wire logic               obj_abort,
	input wire svc_pkg::svc_comm_t comm_state,
	input wire logic               tool_wr,
	input wire logic               tool_ack,
	input wire logic               tool_abort,
	input wire logic               servo_on,
	input wire logic               tool_command_warning,
	input wire logic [15:0]        torque_limit,
	input wire logic [15:0]        status_word
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire cw_hit = obj_wr && obj_index == IDX_CTRL && obj_sub == SUB0;
	// Quiet lead-in so the status byte seen is already settled
	sequence cw_cmd(logic [15:0] v, logic [7:0] f);
		!cw_hit [*2] ##1 cw_hit && obj_wdata[15:0] == v && status_word[7:0] == f;
	endsequence
	obj_answer_a: assert property ((obj_wr || obj_rd) |=> obj_ack != obj_abort)
		else $error("object request without single answer");
	shutdown_step_a: assert property (cw_cmd(CW_SHUTDOWN, SW_SOD) |=> ##1
		status_word[7:0] == SW_RTSO) else $error("shutdown step wrong");
	switch_on_step_a: assert property (cw_cmd(CW_SWITCH_ON, SW_RTSO) |=> ##1
		status_word[7:0] == SW_SO) else $error("switch on step wrong");
	enable_step_a: assert property (cw_cmd(CW_ENABLE_OP, SW_SO) ##0 !tool_command_warning
		|=> ##1 status_word[7:0] == SW_OE && servo_on) else $error("enable step wrong");
	disable_step_a: assert property (cw_cmd(CW_SWITCH_ON, SW_OE) |=> ##1
		status_word[7:0] == SW_SO) else $error("disable step wrong");
	invalid_hold_a: assert property (cw_cmd(CW_ENABLE_OP, SW_SOD) |=> ##1
		status_word[7:0] == SW_SOD) else $error("invalid command moved state");
	torque_init_a: assert property (comm_state == CS_INIT && $past(comm_state) == CS_INIT
		|-> torque_limit == TORQUE_FULL) else $error("torque limit applied in init");
	tool_refuse_a: assert property (tool_wr && comm_state != CS_INIT
		|=> tool_abort && !tool_ack) else $error("tool write taken out of init");
endmodule
bind svc_drive_ctrl svc_chk u_svc_chk (.ref_clk, .reset, .obj_wr, .obj_rd, .obj_index,
	.obj_sub, .obj_wdata, .obj_ack, .obj_abort, .comm_state, .tool_wr, .tool_ack, .tool_abort,
	.servo_on, .tool_command_warning, .torque_limit, .status_word);

// *** testbench/svc_master_model.sv ***
`timescale 1ns/1ps
module svc_master_model (
	input  wire logic        ref_clk,
	output logic             obj_wr,
	output logic             obj_rd,
	output logic [15:0]      obj_index,
	output logic [7:0]       obj_sub,
	output logic [31:0]      obj_wdata,
	input  wire logic [31:0] obj_rdata,
	input  wire logic        obj_ack,
	input  wire logic        obj_abort,
	output logic             comm_req,
	output logic [3:0]       comm_req_state
);
	initial
	begin
		{obj_wr, obj_rd, comm_req, obj_index, obj_sub, obj_wdata} = 59'h0;
		comm_req_state = 4'h1;
	end
	// Released index and data lines show the inverse; obj_sub keeps a stale copy
	task automatic xfer(input logic rd, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		@(negedge ref_clk);
		{obj_rd, obj_wr, obj_index, obj_sub, obj_wdata} = {rd, !rd, i, s, d};
		@(negedge ref_clk);
		// Answer stands for one cycle only, so take it before the next edge
		q = obj_rdata;
		r = {obj_ack, obj_abort};
		{obj_rd, obj_wr, obj_index, obj_wdata} = {2'h0, ~i, ~d};
	endtask
	// Caller confirms each state before asking the next
	task automatic step(input logic [3:0] s);
		@(negedge ref_clk);
		{comm_req, comm_req_state} = {1'h1, s};
		@(negedge ref_clk);
		{comm_req, comm_req_state} = {1'h0, ~s};
	endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import svc_pkg::*;
	logic        ref_clk = 1'h0;
	logic        reset = 1'h1;
	logic        obj_wr, obj_rd, comm_req, obj_ack, obj_abort, tool_ack, tool_abort;
	logic        tool_wr = 1'h0, tool_servo_req = 1'h0, tool_motor_run = 1'h0;
	logic        incremental_mode = 1'h0, homing_done = 1'h0;
	logic        servo_on, motion_start, tool_command_warning, command_conflict_error;
	logic        state_change_while_running_error, sync_pulse, latch_pulse;
	logic [15:0] obj_index, status_word, torque_limit;
	logic [15:0] tool_index = 16'h0000;
	logic [7:0]  obj_sub;
	logic [31:0] obj_wdata, obj_rdata, target_pos_cmd, vel_cmd, acc_cmd, dec_cmd, q;
	logic [31:0] tool_wdata = 32'h0000_0000;
	logic [3:0]  comm_req_state;
	logic [1:0]  r;
	svc_comm_t   comm_state;
	int          mismatches = 0;
	int          n_compared = 0;
	logic [23:0] cfg_k [12] = '{K_PVEL, K_MAX_PVEL, K_MAX_MSPD, K_PACC, K_MAX_ACC, K_PDEC,
		K_MAX_DEC, K_OUT_TYPE, K_IN_TYPE, K_LIM_MIN, K_LIM_MAX, K_TGT_POS};
	logic [31:0] cfg_d [12] = '{32'h0000_01F4, 32'h0000_012C, 32'h0000_00C8, 32'h0000_0384,
		32'h0000_0064, 32'h0000_0320, 32'h0000_0032, 32'h0000_0002, 32'h0000_0002,
		32'h0000_0000, 32'h0000_03E8, 32'h0000_1388};
	svc_drive_ctrl u_svc_drive_ctrl (.ref_clk, .reset, .obj_wr, .obj_rd, .obj_index, .obj_sub,
		.obj_wdata, .obj_rdata, .obj_ack, .obj_abort, .comm_req, .comm_req_state, .comm_state,
		.tool_wr, .tool_index, .tool_sub(8'h00), .tool_wdata, .tool_ack, .tool_abort,
		.tool_servo_req, .tool_motor_run, .incremental_mode, .homing_done,
		.alarm_clear(1'h0), .servo_on, .motion_start, .target_pos_cmd, .vel_cmd, .acc_cmd,
		.dec_cmd, .torque_limit, .status_word, .tool_command_warning, .command_conflict_error,
		.state_change_while_running_error, .sync_pulse, .latch_pulse);
	svc_master_model u_svc_master_model (.ref_clk, .obj_wr, .obj_rd, .obj_index, .obj_sub,
		.obj_wdata, .obj_rdata, .obj_ack, .obj_abort, .comm_req, .comm_req_state);
	always #5 ref_clk = ~ref_clk;
	task automatic finish_test;
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [23:0] k, input logic [31:0] d, input logic [1:0] e);
		u_svc_master_model.xfer(1'h0, k[23:8], k[7:0], d, q, r);
		`CHK(r, e)
	endtask
	task automatic rd(input logic [23:0] k, input logic [31:0] e);
		u_svc_master_model.xfer(1'h1, k[23:8], k[7:0], 32'h0000_0000, q, r);
		`CHK(q, e)
	endtask
	task automatic cw(input logic [15:0] v, input logic [15:0] e);
		wr(K_CTRL, {16'h0000, v}, 2'h2);
		@(negedge ref_clk);
		`CHK(status_word, e)
	endtask
	task automatic twr(input logic [31:0] d, input logic [1:0] e);
		@(negedge ref_clk);
		{tool_wr, tool_index, tool_wdata} = {1'h1, IDX_EXT6, d};
		@(negedge ref_clk);
		`CHK({tool_ack, tool_abort}, e)
		{tool_wr, tool_index, tool_wdata} = {1'h0, ~IDX_EXT6, ~d};
	endtask
	task automatic step(input logic [3:0] s);
		u_svc_master_model.step(s);
		@(negedge ref_clk);
		`CHK(comm_state, s)
	endtask
	initial
	begin
		repeat (5) @(negedge ref_clk);
		reset = 1'h0;
		`CHK(status_word, 16'h0040)
		`CHK(torque_limit, TORQUE_FULL)
		rd(K_EXT6, 32'h0000_0000);
		wr(K_STAT, 32'h0000_0000, 2'h1);
		wr(24'h12_3400, 32'h0000_0000, 2'h1);
		cw(CW_ENABLE_OP, 16'h0040);
		cw(CW_SHUTDOWN, 16'h0021);
		cw(CW_SWITCH_ON, 16'h0023);
		cw(CW_ENABLE_OP, 16'h0027);
		`CHK(servo_on, 1'h1)
		cw(16'h001F, 16'h1027);
		`CHK(motion_start, 1'h1)
		cw(CW_SWITCH_ON, 16'h0023);
		`CHK(servo_on, 1'h0)
		wr(K_MAX_TRQ, 32'h0000_0123, 2'h2);
		`CHK(torque_limit, TORQUE_FULL)
		twr(32'h0000_0001, 2'h2);
		rd(K_EXT6, 32'h0000_0001);
		step(CS_PREOP);
		@(negedge ref_clk);
		`CHK(torque_limit, 16'h0123)
		twr(32'h0000_0000, 2'h1);
		for (int k = 0; k < 12; k++) wr(cfg_k[k], cfg_d[k], 2'h2);
		repeat (2) @(negedge ref_clk);
		`CHK(vel_cmd, 32'h0000_00C8)
		`CHK(acc_cmd, 32'h0000_0064)
		`CHK(dec_cmd, 32'h0000_0032)
		`CHK(target_pos_cmd, 32'h0000_03E8)
		`CHK(status_word, 16'h0823)
		step(CS_SAFEOP);
		`CHK({sync_pulse, latch_pulse}, 2'h3)
		step(CS_OP);
		{tool_servo_req, tool_motor_run} = 2'h3;
		repeat (2) @(negedge ref_clk);
		`CHK({tool_command_warning, servo_on}, 2'h3)
		cw(CW_ENABLE_OP, 16'h0823);
		`CHK(command_conflict_error, 1'h1)
		step(CS_SAFEOP);
		@(negedge ref_clk);
		`CHK(state_change_while_running_error, 1'h1)
		// Homing report held off while the tool moves the motor in incremental mode
		{homing_done, incremental_mode} = 2'h3;
		wr(K_MODE, 32'h0000_0006, 2'h2);
		@(negedge ref_clk);
		`CHK(status_word[SW_MODE_BIT], 1'h0)
		incremental_mode = 1'h0;
		repeat (2) @(negedge ref_clk);
		`CHK(status_word[SW_MODE_BIT], 1'h1)
		finish_test();
	end
	initial
	begin
		#100us;
		mismatches++;
		finish_test();
	end
endmodule
